// ### acc_file_alu_bit_skip.sv
// Purpose: accumulator/file execution datapath with bit-test skip
// Assumes: decoder inputs and APB are on pclk; one instruction per valid cycle
// Notes:   software may only write data registers while the run bit is low
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Add literal to accumulator, update three flags
// - Add accumulator and file, update three flags
// - Destination zero writes accumulator only
// - Destination one writes file register back
// - Set file bit, flags unchanged
// - Clear file bit, flags unchanged
// - AND literal into accumulator, Z only
// - AND accumulator with file, Z only
// - Bit one: next instruction becomes no-op
// - Bit zero: skip next, flags unchanged
module acc_file_alu_bit_skip
  import acc_alu_pkg::*;
#(
  parameter int CNT_WIDTH = CNT_W
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          ce,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [acc_alu_pkg::PADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          instr_valid,
  input  wire acc_alu_pkg::op_t              instr_op,
  input  wire logic [acc_alu_pkg::DATA_W-1:0] instr_literal,
  input  wire logic [acc_alu_pkg::FILE_ADDR_W-1:0] instr_file_addr,
  input  wire logic                          instr_dest,
  input  wire logic [acc_alu_pkg::BIT_IDX_W-1:0] instr_bit,
  output logic      [acc_alu_pkg::DATA_W-1:0] acc_out,
  output logic      [acc_alu_pkg::FLAG_W-1:0] flags_out,
  output logic                               nop_slot
);
  import acc_alu_pkg::*;

  logic [DATA_W-1:0]    acc;
  logic [FLAG_W-1:0]    flags;
  logic [DATA_W-1:0]    file_mem [FILE_DEPTH];
  logic                 run;
  logic [CNT_WIDTH-1:0] skip_cnt;
  seq_state_t           state;
  seq_state_t           next_state;

  logic [DATA_W-1:0]    file_rd;
  logic [DATA_W-1:0]    operand;
  logic [DATA_W-1:0]    result;
  logic                 alu_c;
  logic                 alu_dc;
  logic                 alu_z;
  logic                 bit_value;
  logic                 exec;
  logic                 discard;
  logic                 is_file_alu;
  logic                 acc_we;
  logic                 file_we;
  logic                 skip_taken;

  logic                 access;
  logic                 complete;
  logic                 in_file;
  logic                 hit_ctrl;
  logic                 hit_acc;
  logic                 hit_status;
  logic                 hit_cnt;
  logic                 bus_err;
  logic                 bus_wr;
  logic [31:0]          rd_mux;
  logic [FILE_ADDR_W-1:0] bus_idx;

  assign file_rd = file_mem[instr_file_addr];
  assign operand = (instr_op == OP_ADD_LITERAL_TO_ACC || instr_op == OP_AND_LITERAL_WITH_ACC)
                   ? instr_literal : file_rd;

  acc_alu_core u_core (
    .op          (instr_op),
    .acc         (acc),
    .operand     (operand),
    .bit_idx     (instr_bit),
    .result      (result),
    .carry       (alu_c),
    .digit_carry (alu_dc),
    .zero        (alu_z),
    .bit_value   (bit_value)
  );

  // Instruction issue and routing
  always_comb begin
    exec        = ce && run && instr_valid && (state == ST_EXEC);
    discard     = ce && run && instr_valid && (state == ST_SKIP);
    is_file_alu = (instr_op == OP_ADD_ACC_TO_FILE) || (instr_op == OP_AND_ACC_WITH_FILE);
    acc_we      = exec && ((instr_op == OP_ADD_LITERAL_TO_ACC)
                  || (instr_op == OP_AND_LITERAL_WITH_ACC) || (is_file_alu && !instr_dest));
    file_we     = exec && ((is_file_alu && instr_dest) || (instr_op == OP_SET_FILE_BIT)
                  || (instr_op == OP_CLEAR_FILE_BIT));
    skip_taken  = exec && (((instr_op == OP_TEST_BIT_SKIP_IF_ONE) && bit_value)
                  || ((instr_op == OP_TEST_BIT_SKIP_IF_ZERO) && !bit_value));
  end

  // APB decode; one wait state so that read data comes from a flop
  always_comb begin
    access     = psel && penable;
    complete   = access && pready;
    in_file    = (paddr[PADDR_W-1:9] == FILE_REGION);
    bus_idx    = paddr[8:2];
    hit_ctrl   = (paddr == REG_CTRL);
    hit_acc    = (paddr == REG_ACC);
    hit_status = (paddr == REG_STATUS);
    hit_cnt    = (paddr == REG_SKIP_CNT);
    // Data writes while running would race the datapath, so they are refused
    bus_err    = (paddr[1:0] != 2'b00)
                 || !(in_file || hit_ctrl || hit_acc || hit_status || hit_cnt)
                 || (pwrite && hit_cnt)
                 || (pwrite && run && (in_file || hit_acc || hit_status));
    bus_wr     = complete && pwrite && !bus_err;
    rd_mux     = 32'h0000_0000;
    if (in_file) begin
      rd_mux[DATA_W-1:0] = file_mem[bus_idx];
    end else if (hit_ctrl) begin
      rd_mux[CTRL_RUN] = run;
    end else if (hit_acc) begin
      rd_mux[DATA_W-1:0] = acc;
    end else if (hit_status) begin
      rd_mux[FLAG_W-1:0] = flags;
    end else if (hit_cnt) begin
      rd_mux[CNT_WIDTH-1:0] = skip_cnt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= access && !pready;
      pslverr <= access && !pready && bus_err;
      if (access && !pready && !pwrite) begin
        prdata <= bus_err ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= RUN_RST;
    end else if (ce && bus_wr && hit_ctrl) begin
      run <= pwdata[CTRL_RUN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= ACC_RST;
    end else if (ce) begin
      if (acc_we) begin
        acc <= result;
      end else if (bus_wr && hit_acc) begin
        acc <= pwdata[DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_mem[i] <= FILE_RST;
      end
    end else if (ce) begin
      if (file_we) begin
        file_mem[instr_file_addr] <= result;
      end else if (bus_wr && in_file) begin
        file_mem[bus_idx] <= pwdata[DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= STATUS_RST;
    end else if (ce) begin
      if (exec && (instr_op == OP_ADD_LITERAL_TO_ACC || instr_op == OP_ADD_ACC_TO_FILE)) begin
        flags[FLAG_CARRY] <= alu_c;
        flags[FLAG_DIGIT] <= alu_dc;
        flags[FLAG_ZERO]  <= alu_z;
      end else if (exec && (instr_op == OP_AND_LITERAL_WITH_ACC
                            || instr_op == OP_AND_ACC_WITH_FILE)) begin
        flags[FLAG_ZERO]  <= alu_z;
      end else if (bus_wr && hit_status) begin
        flags <= pwdata[FLAG_W-1:0];
      end
    end
  end

  // Skip sequencer: the discarded slot still consumes an instruction cycle
  always_comb begin
    next_state = state;
    case (state)
      ST_EXEC: begin
        if (skip_taken) begin
          next_state = ST_SKIP;
        end
      end
      ST_SKIP: begin
        if (discard) begin
          next_state = ST_EXEC;
        end
      end
      default: next_state = ST_EXEC;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_EXEC;
    end else if (ce) begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_cnt <= '0;
    end else if (ce && discard) begin
      skip_cnt <= skip_cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_out   <= ACC_RST;
      flags_out <= STATUS_RST;
      nop_slot  <= 1'b0;
    end else if (ce) begin
      acc_out   <= acc_we ? result : ((bus_wr && hit_acc) ? pwdata[DATA_W-1:0] : acc);
      flags_out <= flags;
      nop_slot  <= (next_state == ST_SKIP);
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_add_lit;
    exec && instr_op == OP_ADD_LITERAL_TO_ACC |=> acc == $past(acc) + $past(instr_literal);
  endproperty
  a_add_lit: assert property (p_add_lit) else $error("add literal result wrong");

  property p_add_file;
    exec && instr_op == OP_ADD_ACC_TO_FILE && instr_dest
      |=> file_mem[$past(instr_file_addr)] == $past(acc) + $past(file_rd) && $stable(acc);
  endproperty
  a_add_file: assert property (p_add_file) else $error("add to file wrong");

  property p_dest_acc;
    exec && is_file_alu && !instr_dest
      |=> file_mem[$past(instr_file_addr)] == $past(file_rd);
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("file changed with dest 0");

  property p_dest_file;
    exec && instr_op == OP_AND_ACC_WITH_FILE && instr_dest
      |=> file_mem[$past(instr_file_addr)] == ($past(acc) & $past(file_rd));
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("dest 1 write-back wrong");

  property p_set_bit;
    exec && instr_op == OP_SET_FILE_BIT
      |=> file_mem[$past(instr_file_addr)][$past(instr_bit)] == 1'b1 && $stable(flags);
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("set bit wrong");

  property p_clr_bit;
    exec && instr_op == OP_CLEAR_FILE_BIT
      |=> file_mem[$past(instr_file_addr)][$past(instr_bit)] == 1'b0 && $stable(flags);
  endproperty
  a_clr_bit: assert property (p_clr_bit) else $error("clear bit wrong");

  property p_and_lit;
    exec && instr_op == OP_AND_LITERAL_WITH_ACC
      |=> acc == ($past(acc) & $past(instr_literal))
          && flags[FLAG_CARRY] == $past(flags[FLAG_CARRY])
          && flags[FLAG_DIGIT] == $past(flags[FLAG_DIGIT]);
  endproperty
  a_and_lit: assert property (p_and_lit) else $error("and literal wrong");

  property p_and_file_z;
    exec && instr_op == OP_AND_ACC_WITH_FILE
      |=> flags[FLAG_ZERO] == (($past(acc) & $past(file_rd)) == 8'h00)
          && flags[FLAG_CARRY] == $past(flags[FLAG_CARRY]);
  endproperty
  a_and_file_z: assert property (p_and_file_z) else $error("and file flag wrong");

  property p_skip_one;
    exec && instr_op == OP_TEST_BIT_SKIP_IF_ONE && file_rd[instr_bit]
      |=> nop_slot && state == ST_SKIP;
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("skip if one missed");

  property p_skip_zero;
    exec && instr_op == OP_TEST_BIT_SKIP_IF_ZERO
      |=> (state == ST_SKIP) == !$past(file_rd[instr_bit]) && $stable(flags);
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("skip if zero wrong");

  property p_discard;
    discard |=> $stable(acc) && $stable(flags) && state == ST_EXEC;
  endproperty
  a_discard: assert property (p_discard) else $error("discarded slot executed");

  property p_add_flags;
    exec && instr_op == OP_ADD_LITERAL_TO_ACC
      |=> flags[FLAG_ZERO] == (acc == 8'h00)
          && flags[FLAG_CARRY] == (({1'b0, $past(acc)} + {1'b0, $past(instr_literal)}) > 9'h0FF);
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("add flags wrong");

endmodule : acc_file_alu_bit_skip
`default_nettype wire

// ### acc_alu_pkg.sv
// Purpose: shared constants and types for the accumulator/file datapath
// Assumes: one clock, APB register access, 32-bit bus data
// Notes:   opcode values are the decoder-facing encoding of this block
`default_nettype none
package acc_alu_pkg;

  localparam int DATA_W      = 8;
  localparam int FILE_ADDR_W = 7;
  localparam int FILE_DEPTH  = 128;
  localparam int BIT_IDX_W   = 3;
  localparam int PADDR_W     = 12;
  localparam int CNT_W       = 16;

  // Decoder opcode encoding
  typedef enum logic [3:0] {
    OP_NONE                 = 4'h0,
    OP_ADD_LITERAL_TO_ACC   = 4'h1,
    OP_ADD_ACC_TO_FILE      = 4'h2,
    OP_SET_FILE_BIT         = 4'h3,
    OP_CLEAR_FILE_BIT       = 4'h4,
    OP_AND_LITERAL_WITH_ACC = 4'h5,
    OP_AND_ACC_WITH_FILE    = 4'h6,
    OP_TEST_BIT_SKIP_IF_ONE = 4'h7,
    OP_TEST_BIT_SKIP_IF_ZERO = 4'h8
  } op_t;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_EXEC = 2'b01,
    ST_SKIP = 2'b10
  } seq_state_t;

  // Status and control field positions
  localparam int FLAG_W        = 3;
  localparam int FLAG_CARRY    = 0;
  localparam int FLAG_DIGIT    = 1;
  localparam int FLAG_ZERO     = 2;
  localparam int CTRL_RUN      = 0;

  // Register byte addresses
  localparam logic [PADDR_W-1:0] REG_CTRL     = 12'h000;
  localparam logic [PADDR_W-1:0] REG_ACC      = 12'h004;
  localparam logic [PADDR_W-1:0] REG_STATUS   = 12'h008;
  localparam logic [PADDR_W-1:0] REG_SKIP_CNT = 12'h00C;
  localparam logic [2:0]         FILE_REGION  = 3'h1;

  // Reset values
  localparam logic [DATA_W-1:0] ACC_RST    = 8'h00;
  localparam logic [FLAG_W-1:0] STATUS_RST = 3'h0;
  localparam logic [DATA_W-1:0] FILE_RST   = 8'h00;
  localparam logic              RUN_RST    = 1'b0;

  // Instruction-cycle length of a taken bit test
  localparam int SKIP_TAKEN_CYCLES = 2;

endpackage : acc_alu_pkg
`default_nettype wire

// ### acc_alu_core.sv
// Purpose: combinational arithmetic, logic and bit unit
// Assumes: operands already selected by the caller
// Notes:   no state; flags are valid only for the ops that update them
`timescale 1ns/100ps
`default_nettype none
module acc_alu_core
  import acc_alu_pkg::*;
(
  input  wire acc_alu_pkg::op_t          op,
  input  wire logic [acc_alu_pkg::DATA_W-1:0]    acc,
  input  wire logic [acc_alu_pkg::DATA_W-1:0]    operand,
  input  wire logic [acc_alu_pkg::BIT_IDX_W-1:0] bit_idx,
  output logic      [acc_alu_pkg::DATA_W-1:0]    result,
  output logic                           carry,
  output logic                           digit_carry,
  output logic                           zero,
  output logic                           bit_value
);
  import acc_alu_pkg::*;

  logic [DATA_W:0] sum;
  logic [4:0]      low_sum;

  always_comb begin
    sum         = {1'b0, acc} + {1'b0, operand};
    low_sum     = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
    carry       = sum[DATA_W];
    digit_carry = low_sum[4];
    bit_value   = operand[bit_idx];
    result      = operand;
    case (op)
      OP_ADD_LITERAL_TO_ACC,
      OP_ADD_ACC_TO_FILE:      result = sum[DATA_W-1:0];
      OP_AND_LITERAL_WITH_ACC,
      OP_AND_ACC_WITH_FILE:    result = acc & operand;
      OP_SET_FILE_BIT:         result[bit_idx] = 1'b1;
      OP_CLEAR_FILE_BIT:       result[bit_idx] = 1'b0;
      default:                 result = operand;
    endcase
    zero = (result == '0);
  end

endmodule : acc_alu_core
`default_nettype wire

// ### acc_file_alu_bit_skip_tb_top.sv
// Purpose: self-checking bench for the accumulator/file datapath
// Assumes: one wait state APB, instructions taken only while run is set
// Notes:   file contents are checked by reading them back over APB
`timescale 1ns/100ps
`default_nettype none
module acc_file_alu_bit_skip_tb_top;
  import acc_alu_pkg::*;
  localparam int TIMEOUT_CYCLES = 30000;
  logic                   pclk, presetn, ce, psel, penable, pwrite;
  logic [PADDR_W-1:0]     paddr;
  logic [31:0]            pwdata, prdata, rd, r;
  logic                   pready, pslverr, er, instr_valid, instr_dest, nop_slot;
  op_t                    instr_op;
  logic [DATA_W-1:0]      instr_literal, acc_out, m_acc;
  logic [FILE_ADDR_W-1:0] instr_file_addr;
  logic [BIT_IDX_W-1:0]   instr_bit;
  logic [FLAG_W-1:0]      flags_out, m_flags, m_flags_d;
  logic [DATA_W-1:0]      m_file [FILE_DEPTH];
  logic                   m_skip, m_run;
  logic [15:0]            m_cnt;
  int                     err_count, total_checks, cycles, seed;

  acc_file_alu_bit_skip #(.CNT_WIDTH(16)) dut_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_literal(instr_literal),
    .instr_file_addr(instr_file_addr), .instr_dest(instr_dest),
    .instr_bit(instr_bit), .acc_out(acc_out), .flags_out(flags_out),
    .nop_slot(nop_slot)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  always @(posedge pclk) begin
    cycles++;
    if (cycles == TIMEOUT_CYCLES) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Returns {carry, digit carry, sum}
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] lo;
    s = {1'b0, a} + {1'b0, b};
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {s[8], lo[4], s[7:0]};
  endfunction : add8

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) err_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Applies what the design sampled at this edge to the model
  task automatic step();
    logic [9:0] s;
    logic [7:0] f;
    logic [7:0] res;
    if (ce !== 1'b1) return;
    m_flags_d = m_flags;
    if (!(m_run && instr_valid)) return;
    if (m_skip) begin
      m_skip = 1'b0;
      m_cnt++;
      return;
    end
    f = m_file[instr_file_addr];
    res = m_acc;
    case (instr_op)
      OP_ADD_LITERAL_TO_ACC, OP_ADD_ACC_TO_FILE: begin
        s = add8(m_acc, (instr_op == OP_ADD_ACC_TO_FILE) ? f : instr_literal);
        res = s[7:0];
        m_flags = {s[7:0] == 8'h00, s[8], s[9]};
      end
      OP_AND_LITERAL_WITH_ACC: res = m_acc & instr_literal;
      OP_AND_ACC_WITH_FILE:    res = m_acc & f;
      OP_SET_FILE_BIT:         m_file[instr_file_addr][instr_bit] = 1'b1;
      OP_CLEAR_FILE_BIT:       m_file[instr_file_addr][instr_bit] = 1'b0;
      OP_TEST_BIT_SKIP_IF_ONE: m_skip = f[instr_bit];
      OP_TEST_BIT_SKIP_IF_ZERO: m_skip = !f[instr_bit];
      default: ;
    endcase
    if (instr_op inside {OP_AND_LITERAL_WITH_ACC, OP_AND_ACC_WITH_FILE}) begin
      m_flags[FLAG_ZERO] = (res == 8'h00);
    end
    if (instr_op inside {OP_ADD_ACC_TO_FILE, OP_AND_ACC_WITH_FILE} && instr_dest) begin
      m_file[instr_file_addr] = res;
    end else begin
      m_acc = res;
    end
  endtask : step

  task automatic issue(input logic v, input op_t op, input logic [7:0] lit,
                       input logic [6:0] fa, input logic d, input logic [2:0] b, input logic c);
    @(posedge pclk);
    step();
    ce <= c;
    instr_valid <= v;
    instr_op <= op;
    instr_literal <= lit;
    instr_file_addr <= fa;
    instr_dest <= d;
    instr_bit <= b;
    @(negedge pclk);
    chk(32'(acc_out), 32'(m_acc));
    chk(32'(flags_out), 32'(m_flags_d));
    chk(32'(nop_slot), 32'(m_skip));
  endtask : issue

  initial begin
    seed = 58;
    {presetn, psel, penable, pwrite, instr_valid, instr_dest} = '0;
    ce = 1'b1;
    paddr = '0;
    pwdata = '0;
    instr_op = OP_NONE;
    {instr_literal, instr_file_addr, instr_bit} = '0;
    {m_acc, m_flags, m_flags_d, m_skip, m_run, m_cnt} = '0;
    foreach (m_file[i]) m_file[i] = 8'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    for (int i = 0; i < FILE_DEPTH; i++) begin
      r = $random(seed);
      apb(1'b1, {FILE_REGION, 7'(i), 2'h0}, r);
      chk(32'(er), 32'h0);
      m_file[i] = r[7:0];
    end
    apb(1'b1, REG_ACC, 32'h0000_00FF);
    m_acc = 8'hFF;
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, er} ^ rd, 32'h1);
    apb(1'b1, REG_SKIP_CNT, 32'h5);
    chk(32'(er), 32'h1);
    apb(1'b1, REG_CTRL, 32'h1);
    m_run = 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h1);
    // Carry and digit carry out of both nibbles, zero result
    issue(1'b1, OP_ADD_LITERAL_TO_ACC, 8'h01, 7'h0, 1'b0, 3'h0, 1'b1);
    issue(1'b1, OP_ADD_LITERAL_TO_ACC, 8'h0F, 7'h0, 1'b0, 3'h0, 1'b1);
    issue(1'b1, OP_ADD_LITERAL_TO_ACC, 8'h01, 7'h0, 1'b0, 3'h0, 1'b1);
    issue(1'b1, OP_AND_LITERAL_WITH_ACC, 8'h0F, 7'h0, 1'b0, 3'h0, 1'b1);
    // Taken skip followed by a skip that must be discarded
    issue(1'b1, OP_SET_FILE_BIT, 8'h00, 7'h7F, 1'b0, 3'h7, 1'b1);
    issue(1'b1, OP_TEST_BIT_SKIP_IF_ONE, 8'h00, 7'h7F, 1'b0, 3'h7, 1'b1);
    issue(1'b1, OP_TEST_BIT_SKIP_IF_ONE, 8'h00, 7'h7F, 1'b0, 3'h7, 1'b1);
    issue(1'b1, OP_CLEAR_FILE_BIT, 8'h00, 7'h7F, 1'b0, 3'h0, 1'b1);
    issue(1'b1, OP_TEST_BIT_SKIP_IF_ZERO, 8'h00, 7'h7F, 1'b0, 3'h0, 1'b1);
    issue(1'b1, OP_ADD_ACC_TO_FILE, 8'h00, 7'h7F, 1'b1, 3'h0, 1'b1);
    issue(1'b1, OP_ADD_ACC_TO_FILE, 8'h00, 7'h7F, 1'b1, 3'h0, 1'b1);
    for (int i = 0; i < 3000; i++) begin
      r = $random(seed);
      issue(r[0] | r[1], op_t'(4'(r[11:8] % 4'h9)), r[19:12], r[26:20], r[27], r[30:28],
            r[31] | r[2] | r[3]);
    end
    issue(1'b0, OP_NONE, 8'h00, 7'h0, 1'b0, 3'h0, 1'b1);
    // Data registers are locked while running
    apb(1'b1, REG_ACC, 32'h0000_005A);
    chk(32'(er), 32'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'(m_flags));
    apb(1'b0, REG_SKIP_CNT, 32'h0);
    chk(rd, 32'(m_cnt));
    apb(1'b1, REG_CTRL, 32'h0);
    m_run = 1'b0;
    issue(1'b1, OP_ADD_LITERAL_TO_ACC, 8'h55, 7'h0, 1'b0, 3'h0, 1'b1);
    issue(1'b0, OP_NONE, 8'h00, 7'h0, 1'b0, 3'h0, 1'b1);
    for (int i = 0; i < FILE_DEPTH; i++) begin
      apb(1'b0, {FILE_REGION, 7'(i), 2'h0}, 32'h0);
      chk(rd, 32'(m_file[i]));
    end
    apb(1'b0, REG_ACC, 32'h0);
    chk(rd, 32'(m_acc));
    // Status is writable while stopped; misaligned access is refused
    apb(1'b1, REG_STATUS, 32'h0000_0005);
    chk(32'(er), 32'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h5);
    apb(1'b0, 12'h002, 32'h0);
    chk(32'(er), 32'h1);
    give_verdict();
  end
endmodule : acc_file_alu_bit_skip_tb_top
`default_nettype wire
